//--- pkg/eehc_pkg.sv
// Purpose: shared constants and types of the serial EEPROM host controller
// Assumes: 20 MHz core clock; serial clock made here by a divider
// Notes:   opcodes are the device instruction bytes
package eehc_pkg;

	localparam logic [7:0] OPC_READ      = 8'h03;
	localparam logic [7:0] OPC_WRITE     = 8'h02;
	localparam logic [7:0] OPC_CLR_PERMIT = 8'h04;
	localparam logic [7:0] OPC_SET_PERMIT = 8'h06;
	localparam logic [7:0] OPC_RD_STATE  = 8'h05;
	localparam logic [7:0] OPC_WR_STATE  = 8'h01;

	localparam int ARRAY_ADDR_W = 11;
	localparam int WIRE_ADDR_W  = 16;
	localparam int PAGE_BYTES   = 16;
	localparam int SCK_HALF_CYC = 2;
	localparam int CS_GAP_CYC   = 4;
	localparam logic [2:0] BIT_MSB = 3'h7;
	localparam logic [15:0] LEN_ONE = 16'h0001;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_LEAD  = 3'b001,
		ST_SHIFT = 3'b010,
		ST_NEXT  = 3'b011,
		ST_TAIL  = 3'b100,
		ST_GAP   = 3'b101
	} eehc_state_e;

	typedef enum logic [1:0] {
		PH_OPC  = 2'b00,
		PH_ADRH = 2'b01,
		PH_ADRL = 2'b10,
		PH_DATA = 2'b11
	} eehc_phase_e;

endpackage

//--- rtl/eehc_buf2.sv
// Purpose: small flop buffer with valid/ready on both sides
// Assumes: DEPTH is a power of two, default two entries
// Notes:   in_ready low when full; out_valid low when empty
`timescale 1ns/1ps
module eehc_buf2 #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	input  wire logic             core_clk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [IW:0] FULL = (IW + 1)'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [IW-1:0]    wr_idx;
	logic [IW-1:0]    rd_idx;
	logic [IW:0]      count;
	logic [IW-1:0]    next_wr_idx;
	logic [IW-1:0]    next_rd_idx;
	logic [IW:0]      next_count;
	logic             push;
	logic             pop;

	always_comb begin
		in_ready    = (count != FULL);
		out_valid   = (count != '0);
		out_data    = mem[rd_idx];
		push        = in_valid && in_ready;
		pop         = out_valid && out_ready;
		next_wr_idx = push ? wr_idx + 1'b1 : wr_idx;
		next_rd_idx = pop ? rd_idx + 1'b1 : rd_idx;
		next_count  = count + {{IW{1'b0}}, push} - {{IW{1'b0}}, pop};
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_idx <= '0;
			rd_idx <= '0;
			count  <= '0;
		end else begin
			wr_idx <= next_wr_idx;
			rd_idx <= next_rd_idx;
			count  <= next_count;
		end
	end

	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wr_idx] <= in_data;
		end
	end
endmodule

//--- rtl/eehc_host.sv
// Purpose: host controller driving a serial EEPROM over its four pins plus pause
// Assumes: core_clk 20 MHz; miso arrives from outside and is synchronised
// Notes:   one command per frame; read bytes leave through a two-entry buffer
//
// Behaviour
// [R1] pause pin stays high unless a pause is deliberately requested
// [R2] pause asserts only while serial clock is low, else after next fall
// [R3] during pause chip select stays low and all shifting freezes
// [R4] pause releases only while serial clock is low
// [R5] device floats its output on pause fall, drives again on rise
// [R6] after pause the transfer continues from the same bit
// [R7] device captures 8-bit instruction on rising clock edges
// [R8] chip select low and pause high for a whole operation
// [R9] all bytes shifted most significant bit first
// [R10] first bit is sampled on first rising edge after select
// [R11] 03 reads array, 05 reads status
// [R12] 02 writes array, 01 writes status
// [R13] 06 sets write permission latch, 04 clears it
// [R14] read opcode then 16-bit address, top five bits ignored
// [R15] device streams addressed byte and following bytes while clocked
// [R16] read pointer increments per byte, wrapping 07FF to 0000
// [R17] sequential read ends when chip select goes high
// [R18] permission set only if select rises after enable opcode
// [R19] write is opcode, address, then bytes within one page
// [R20] bytes past page end wrap to page start
// [R21] select must rise right after D0 of a full byte
// [R22] array reads not serviced during internal write
// [R23] latch cleared when internal write finishes
// [R24] device changes output after falling edges, latches on rising
// [R25] select high keeps device output floating, standby
// [R26] started programming runs to completion regardless of select
// [R27] internal write cycle lasts at most 5 ms
// [R28] write-in-progress shown from cycle start until completion
`timescale 1ns/1ps
module eehc_host
	import eehc_pkg::*;
#(
	parameter int PAGE = PAGE_BYTES,
	parameter int HALF = SCK_HALF_CYC,
	parameter int GAP  = CS_GAP_CYC
) (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        cmd_valid,
	output logic             cmd_ready,
	input  wire logic [7:0]  cmd_opcode,
	input  wire logic [15:0] cmd_addr,
	input  wire logic [15:0] cmd_len,
	input  wire logic        wr_valid,
	output logic             wr_ready,
	input  wire logic [7:0]  wr_data,
	output logic             rd_valid,
	input  wire logic        rd_ready,
	output logic [7:0]       rd_data,
	input  wire logic        pause_req,
	output logic             busy,
	output logic             paused,
	output logic             spi_cs_n,
	output logic             spi_sck,
	output logic             spi_mosi,
	input  wire logic        spi_miso,
	output logic             spi_hold_n
);
	localparam int PW = $clog2(PAGE);
	localparam logic [15:0] PAGE_W = 16'(PAGE);
	localparam logic [7:0]  GAP_W  = 8'(GAP);

	logic        rst_meta;
	logic        rst_sync_n;
	logic        miso_meta;
	logic        miso_s;
	logic        tick;
	logic        buf_in_ready;

	eehc_state_e state;
	eehc_state_e next_state;
	eehc_phase_e phase;
	eehc_phase_e next_phase;
	logic [7:0]  op;
	logic [7:0]  next_op;
	logic [15:0] addr;
	logic [15:0] next_addr;
	logic [15:0] remain;
	logic [15:0] next_remain;
	logic [7:0]  sh_tx;
	logic [7:0]  next_sh_tx;
	logic [7:0]  sh_rx;
	logic [7:0]  next_sh_rx;
	logic [2:0]  bit_cnt;
	logic [2:0]  next_bit_cnt;
	logic [7:0]  rx_byte;
	logic [7:0]  next_rx_byte;
	logic        rx_pend;
	logic        next_rx_pend;
	logic [7:0]  gap_cnt;
	logic [7:0]  next_gap_cnt;
	logic        next_sck;
	logic        next_cs_n;
	logic        next_mosi;
	logic        next_hold_n;

	logic        op_is_read;
	logic        op_has_addr;
	logic [15:0] room;
	logic [15:0] len_eff;
	logic        can_pause;
	logic [7:0]  load_byte;
	logic        load_ok;

	// reset release and miso synchroniser
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta   <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta   <= 1'b1;
			rst_sync_n <= rst_meta;
		end
	end

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			miso_meta <= 1'b0;
			miso_s    <= 1'b0;
		end else begin
			miso_meta <= spi_miso;
			miso_s    <= miso_meta;
		end
	end

	eehc_tick #(
		.DIV (HALF)
	) u_tick (
		.core_clk (core_clk),
		.rst_n    (rst_sync_n),
		.tick     (tick)
	);

	eehc_buf2 #(
		.WIDTH (8),
		.DEPTH (2)
	) u_rxbuf (
		.core_clk  (core_clk),
		.rst_n     (rst_sync_n),
		.in_valid  (rx_pend),
		.in_ready  (buf_in_ready),
		.in_data   (rx_byte),
		.out_valid (rd_valid),
		.out_ready (rd_ready),
		.out_data  (rd_data)
	);

	always_comb begin
		op_is_read  = (op == OPC_READ) || (op == OPC_RD_STATE);
		op_has_addr = (op == OPC_READ) || (op == OPC_WRITE);
		room        = PAGE_W - {{(16 - PW){1'b0}}, cmd_addr[PW-1:0]};
		if (cmd_opcode == OPC_WRITE) begin
			len_eff = (cmd_len > room) ? room : cmd_len; // R19 R20
		end else if (cmd_opcode == OPC_WR_STATE) begin
			len_eff = LEN_ONE;
		end else if (cmd_opcode == OPC_READ || cmd_opcode == OPC_RD_STATE) begin
			len_eff = cmd_len;
		end else begin
			len_eff = '0;
		end
		can_pause = (state == ST_SHIFT) || (state == ST_NEXT);
		case (phase)
			PH_ADRH: load_byte = addr[15:8];
			PH_ADRL: load_byte = addr[7:0];
			default: load_byte = op_is_read ? 8'h00 : wr_data;
		endcase
		load_ok   = (phase != PH_DATA) || (op_is_read ? !rx_pend : wr_valid);
		cmd_ready = (state == ST_IDLE);
		// a pause taken this cycle must not swallow the offered byte
		wr_ready  = (state == ST_NEXT) && (phase == PH_DATA) && !op_is_read
			&& spi_hold_n && !pause_req;
		busy      = (state != ST_IDLE);
		paused    = !spi_hold_n;
	end

	always_comb begin
		next_state   = state;
		next_phase   = phase;
		next_op      = op;
		next_addr    = addr;
		next_remain  = remain;
		next_sh_tx   = sh_tx;
		next_sh_rx   = sh_rx;
		next_bit_cnt = bit_cnt;
		next_rx_byte = rx_byte;
		next_rx_pend = rx_pend && !buf_in_ready;
		next_gap_cnt = gap_cnt;
		next_sck     = spi_sck;
		next_cs_n    = spi_cs_n;
		next_mosi    = spi_mosi;
		next_hold_n  = spi_hold_n;

		if (!spi_hold_n) begin
			// frozen: nothing shifts, select held low
			if (!pause_req && !spi_sck) begin
				next_hold_n = 1'b1; // R4
			end
		end else if (pause_req && can_pause && !spi_sck) begin
			next_hold_n = 1'b0; // R2 R3
		end else begin
			case (state)
				ST_IDLE: begin
					if (cmd_valid) begin
						next_op      = cmd_opcode;
						next_addr    = {5'h00, cmd_addr[ARRAY_ADDR_W-1:0]}; // R14
						next_remain  = len_eff;
						next_phase   = PH_OPC;
						next_sh_tx   = cmd_opcode;
						next_mosi    = cmd_opcode[7]; // R10
						next_bit_cnt = BIT_MSB;
						next_cs_n    = 1'b0; // R8
						next_state   = ST_LEAD;
					end
				end
				ST_LEAD: begin
					if (tick) begin
						next_state = ST_SHIFT;
					end
				end
				ST_SHIFT: begin
					if (tick && !spi_sck) begin
						next_sck = 1'b1;
					end else if (tick) begin
						// sample at end of high phase: synchroniser lags two cycles
						next_sck   = 1'b0;
						next_sh_rx = {sh_rx[6:0], miso_s}; // R9
						if (bit_cnt != 3'h0) begin
							next_bit_cnt = bit_cnt - 1'b1;
							next_sh_tx   = {sh_tx[6:0], 1'b0};
							next_mosi    = sh_tx[6]; // R9
						end else begin
							next_state = ST_NEXT;
							case (phase)
								PH_OPC: begin
									if (op_has_addr) begin
										next_phase = PH_ADRH;
									end else if (remain != '0) begin
										next_phase = PH_DATA;
									end else begin
										next_state = ST_TAIL; // R18
									end
								end
								PH_ADRH: next_phase = PH_ADRL;
								PH_ADRL: begin
									if (remain != '0) begin
										next_phase = PH_DATA;
									end else begin
										next_state = ST_TAIL;
									end
								end
								default: begin
									if (op_is_read) begin
										next_rx_byte = {sh_rx[6:0], miso_s};
										next_rx_pend = 1'b1;
									end
									next_remain = remain - 1'b1;
									if (remain == LEN_ONE) begin
										next_state = ST_TAIL; // R17 R21
									end
								end
							endcase
						end
					end
				end
				ST_NEXT: begin
					// stall with clock low until the byte can move
					if (load_ok) begin
						next_sh_tx   = load_byte;
						next_mosi    = load_byte[7];
						next_bit_cnt = BIT_MSB;
						next_state   = ST_SHIFT;
					end
				end
				ST_TAIL: begin
					if (tick) begin
						next_cs_n    = 1'b1; // R17 R21
						next_mosi    = 1'b0;
						next_gap_cnt = GAP_W;
						next_state   = ST_GAP;
					end
				end
				ST_GAP: begin
					if (gap_cnt == '0) begin
						next_state = ST_IDLE;
					end else begin
						next_gap_cnt = gap_cnt - 1'b1;
					end
				end
				default: begin
					next_state = ST_IDLE;
					next_cs_n  = 1'b1;
					next_sck   = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state      <= ST_IDLE;
			phase      <= PH_OPC;
			op         <= 8'h00;
			addr       <= 16'h0000;
			remain     <= 16'h0000;
			sh_tx      <= 8'h00;
			sh_rx      <= 8'h00;
			bit_cnt    <= 3'h0;
			rx_byte    <= 8'h00;
			rx_pend    <= 1'b0;
			gap_cnt    <= 8'h00;
			spi_sck    <= 1'b0;
			spi_cs_n   <= 1'b1;
			spi_mosi   <= 1'b0;
			spi_hold_n <= 1'b1; // R1
		end else begin
			state      <= next_state;
			phase      <= next_phase;
			op         <= next_op;
			addr       <= next_addr;
			remain     <= next_remain;
			sh_tx      <= next_sh_tx;
			sh_rx      <= next_sh_rx;
			bit_cnt    <= next_bit_cnt;
			rx_byte    <= next_rx_byte;
			rx_pend    <= next_rx_pend;
			gap_cnt    <= next_gap_cnt;
			spi_sck    <= next_sck;
			spi_cs_n   <= next_cs_n;
			spi_mosi   <= next_mosi;
			spi_hold_n <= next_hold_n;
		end
	end
endmodule

//--- rtl/eehc_tick.sv
// Purpose: one-cycle enable pulse every DIV core cycles
// Assumes: single core clock
// Notes:   paces the serial clock half periods
`timescale 1ns/1ps
module eehc_tick #(
	parameter int DIV = 2
) (
	input  wire logic core_clk,
	input  wire logic rst_n,
	output logic      tick
);
	localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	logic [CW-1:0] cnt;
	logic [CW-1:0] next_cnt;
	logic          next_tick;

	always_comb begin
		next_cnt  = (cnt == LAST) ? '0 : cnt + 1'b1;
		next_tick = (cnt == LAST);
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt  <= '0;
			tick <= 1'b0;
		end else begin
			cnt  <= next_cnt;
			tick <= next_tick;
		end
	end
endmodule

//--- tb/eehc_eeprom.sv
// Purpose: behavioural serial EEPROM on the far side of the host
// Assumes: mode 0 serial clock, 2048 bytes, 16-byte pages
// Notes:   write cycle shortened to WC_NS; output inverted when released
`timescale 1ns/1ps
module eehc_eeprom #(
	parameter int WC_NS = 3000
) (
	input  wire logic cs_n,
	input  wire logic sck,
	input  wire logic mosi,
	input  wire logic hold_n,
	output logic      miso
);
	logic [7:0]  mem [2048];
	logic [7:0]  sh, opc, ob;
	logic [10:0] a;
	logic        write_permit_latch, write_in_progress, so;
	int          n;
	logic [18:0] q[$];
	initial begin
		write_permit_latch = 0;
		write_in_progress = 0;
		so = 0;
		ob = 8'h00;
		n = 0;
		foreach (mem[i]) mem[i] = 8'(i) ^ 8'h5a;
	end
	assign miso = (cs_n || !hold_n) ? ~so : so;
	always @(negedge cs_n) begin
		n = 0;
		opc = 8'h00;
		q.delete();
	end
	always @(posedge sck) if (!cs_n && hold_n) begin
		sh = {sh[6:0], mosi};
		n++;
		if (n == 8) opc = sh;
		if (n > 8 && n <= 24) a = {a[9:0], mosi};
		if (opc == 8'h03 && n >= 24 && n % 8 == 0) begin
			ob = write_in_progress ? 8'h00 : mem[a];
			a++;
		end
		if (opc == 8'h05 && n % 8 == 0) ob = {6'h00, write_permit_latch, write_in_progress};
		if (opc == 8'h02 && n > 24 && n % 8 == 0) begin
			q.push_back({a, sh});
			a[3:0]++;
		end
	end
	always @(negedge sck) if (!cs_n && hold_n) begin
		so = ob[7];
		ob = {ob[6:0], 1'b0};
	end
	always @(posedge cs_n) begin
		if (opc == 8'h06 && n == 8) write_permit_latch = 1;
		if (opc == 8'h04 && n == 8) write_permit_latch = 0;
		if (write_permit_latch && !write_in_progress && n % 8 == 0 && (opc == 8'h01 && n == 16 || opc == 8'h02 && n > 24)) begin
			foreach (q[i]) mem[q[i][18:8]] = q[i][7:0];
			write_in_progress = 1;
			#(WC_NS);
			write_in_progress = 0;
			write_permit_latch = 0;
		end
	end
endmodule

//--- tb/eehc_host_sva.sv
// Purpose: port checker of the serial EEPROM host controller
// Assumes: one core clock domain
// Notes:   bound to every host instance
`timescale 1ns/1ps
module eehc_host_sva #(
	parameter int HALF = 2
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic pause_req,
	input wire logic busy,
	input wire logic spi_cs_n,
	input wire logic spi_sck,
	input wire logic spi_mosi,
	input wire logic spi_hold_n
);
	logic [7:0] hi_cnt;
	logic [7:0] next_hi_cnt;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	always_comb begin
		next_hi_cnt = spi_sck ? hi_cnt + 8'h01 : 8'h00;
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			hi_cnt <= 8'h00;
		else
			hi_cnt <= next_hi_cnt;
	end
	sequence s_selected;
		busy && !spi_cs_n;
	endsequence
	a_take_select: assert property (cmd_valid && cmd_ready |=> s_selected)
		else $error("select not driven after command taken");
	a_idle_clock: assert property (spi_cs_n |-> !spi_sck)
		else $error("serial clock high while deselected");
	a_busy_frame: assert property (!spi_cs_n |-> busy)
		else $error("selected while not busy");
	a_pause_sel: assert property (!spi_hold_n |-> !spi_cs_n)
		else $error("pause pin low while deselected");
	a_pause_freeze: assert property (!spi_hold_n && $past(!spi_hold_n) |->
		$stable(spi_sck) && $stable(spi_mosi) && $stable(spi_cs_n))
		else $error("serial pins moved during pause");
	a_hold_sck_low: assert property ($changed(spi_hold_n) |-> !spi_sck && !$past(spi_sck))
		else $error("pause pin moved with clock high");
	a_pause_release: assert property (!pause_req && !spi_hold_n |=> spi_hold_n)
		else $error("pause not released");
	a_mosi_on_fall: assert property (!spi_cs_n && $past(!spi_cs_n) && $changed(spi_mosi)
		|-> !spi_sck)
		else $error("data out changed with clock high");
	a_sck_high: assert property ($fell(spi_sck) |-> hi_cnt == HALF[7:0])
		else $error("clock high level wrong length");
endmodule
bind eehc_host eehc_host_sva #(.HALF(HALF)) u_sva (.core_clk, .rst_n, .cmd_valid, .cmd_ready,
	.pause_req, .busy, .spi_cs_n, .spi_sck, .spi_mosi, .spi_hold_n);

//--- tb/testbench.sv
// Purpose: self-checking bench of the serial EEPROM host controller
// Assumes: 20 MHz core clock, behavioural device on the serial pins
// Notes:   reference memory follows every committed write
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
	$display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module testbench;
	import eehc_pkg::*;
	logic        core_clk = 0, rst_n = 0, cmd_valid = 0, wr_valid = 0, rd_ready = 0;
	logic        pause_req = 0, cmd_ready, wr_ready, rd_valid, busy, paused;
	logic        spi_cs_n, spi_sck, spi_mosi, spi_miso, spi_hold_n;
	logic [7:0]  cmd_opcode = 8'h00, wr_data = 8'h00, rd_data, st;
	logic [15:0] cmd_addr = 16'h0000, cmd_len = 16'h0000;
	logic [7:0]  ref_mem [2048];
	logic [7:0]  wq[$], rq[$];
	int          bad_count = 0, cmp_count = 0, t;
	bit          pz = 0;
	always #25 core_clk = ~core_clk;
	eehc_host DUT (.core_clk, .rst_n, .cmd_valid, .cmd_ready, .cmd_opcode, .cmd_addr,
		.cmd_len, .wr_valid, .wr_ready, .wr_data, .rd_valid, .rd_ready, .rd_data,
		.pause_req, .busy, .paused, .spi_cs_n, .spi_sck, .spi_mosi, .spi_miso, .spi_hold_n);
	eehc_eeprom u_dev (.cs_n(spi_cs_n), .sck(spi_sck), .mosi(spi_mosi), .hold_n(spi_hold_n),
		.miso(spi_miso));
	always @(posedge core_clk) begin
		if (wr_valid && wr_ready) void'(wq.pop_front());
		if (rd_valid && rd_ready) rq.push_back(rd_data);
		if (rst_n) `CHK(paused, ~spi_hold_n)
		#2;
		wr_valid = wq.size() > 0;
		wr_data = wr_valid ? wq[0] : 8'h00;
		rd_ready = ($urandom % 4) != 0;
		pause_req = pz && ($urandom % 8 == 0);
	end
	task automatic step(input int k);
		repeat (k) @(posedge core_clk);
		#2;
	endtask
	task automatic run(input logic [7:0] op, input logic [15:0] ad, input logic [15:0] ln);
		cmd_opcode = op;
		cmd_addr = ad;
		cmd_len = ln;
		cmd_valid = 1;
		while (cmd_ready !== 1'b1) step(1);
		step(1);
		cmd_valid = 0;
		t = 0;
		while (busy !== 1'b0 && t < 40000) begin
			step(1);
			t++;
		end
	endtask
	task automatic get(input int n);
		t = 0;
		while (rq.size() < n && t < 400) begin
			step(1);
			t++;
		end
	endtask
	task automatic stat;
		run(OPC_RD_STATE, 16'h0000, LEN_ONE);
		get(1);
		st = rq.pop_front();
	endtask
	task automatic poll;
		int k;
		k = 0;
		stat;
		while (st[0] !== 1'b0 && k < 50) begin
			stat;
			k++;
		end
		`CHK(st, 8'h00)
	endtask
	task automatic wr(input logic [15:0] ad, input int n, input logic [15:0] ln, input bit keep);
		for (int i = 0; i < n; i++) begin
			wq.push_back(8'($urandom));
			if (keep) ref_mem[{ad[10:4], 4'(ad[3:0] + i)}] = wq[i];
		end
		run(OPC_WRITE, ad, ln);
	endtask
	task automatic rd(input logic [15:0] ad, input int n);
		run(OPC_READ, ad, 16'(n));
		get(n);
		for (int i = 0; i < n; i++) begin
			st = rq.pop_front();
			`CHK(st, ref_mem[11'(ad[10:0] + i)])
		end
	endtask
	task automatic final_report;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		#2_000_000;
		bad_count++;
		final_report;
	end
	initial begin
		foreach (ref_mem[i]) ref_mem[i] = 8'(i) ^ 8'h5a;
		void'($urandom(86905));
		step(16);
		rst_n = 1;
		`CHK(spi_cs_n, 1'b1)
		`CHK(spi_hold_n, 1'b1)
		`CHK(paused, 1'b0)
		$display("test reset done");
		step(4);
		run(OPC_SET_PERMIT, 16'h0000, 16'h0000);
		stat;
		`CHK(st, 8'h02)
		pz = 1;
		wr(16'hf813, 13, 16'h0014, 1);
		poll;
		rd(16'h0810, 16);
		$display("test page write done");
		rd(16'h07fe, 4);
		$display("test wrap read done");
		run(OPC_SET_PERMIT, 16'h0000, 16'h0000);
		run(OPC_CLR_PERMIT, 16'h0000, 16'h0000);
		wr(16'h0020, 2, 16'h0002, 0);
		stat;
		`CHK(st, 8'h00)
		rd(16'h0020, 2);
		$display("test no permit done");
		run(OPC_SET_PERMIT, 16'h0000, 16'h0000);
		wq.push_back(8'h00);
		run(OPC_WR_STATE, 16'h0000, LEN_ONE);
		poll;
		$display("test state write done");
		final_report;
	end
endmodule
